/* File: bench/cwg_gate_drv.sv */
// Gate driver model: one power switch fed by a generator output.
// Assumes one cycle of propagation; on while the drive equals its active level.
`timescale 1ns/1ps
module cwg_gate_drv
  import cwg_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic drive,
  input  wire logic activeHigh,
  output logic      gateOn
);
  always_ff @(posedge clk_sys)
  begin
    gateOn <= rst_n && drive == activeHigh;
  end
endmodule // cwg_gate_drv

/* File: bench/cwg_top_checker.sv */
// Port-level checks of bus timing, enable, override and oscillator request.
// Assumes it is bound into cwg_top; writes are tracked while ack is high.
`timescale 1ns/1ps
`include "cwg_map.svh"
module cwg_top_checker
  import cwg_pkg::*;
#(
  parameter int NSRC = 4
)(
  input wire logic            clk_sys,
  input wire logic            rst_n,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [31:0]     wb_dat_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_we_i,
  input wire logic [3:0]      wb_sel_i,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_ack_o,
  input wire logic            wb_err_o,
  input wire logic [NSRC-1:0] shutdown_src,
  input wire logic            drive_output_a,
  input wire logic            drive_output_b,
  input wire logic            fast_osc_request
);
  logic [7:0]      c0Q, c0D, c1Q, c1D;
  logic [NSRC-1:0] mskQ, mskD;
  logic            wr, en, req, ovOk;
  assign wr   = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign en   = c0Q[`CWG_C0_EN];
  assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign ovOk = drive_output_a == c1Q[`CWG_C1_OVA_LO] && drive_output_b == c1Q[`CWG_C1_OVB_LO];
  always_comb
  begin
    c0D  = c0Q;
    c1D  = c1Q;
    mskD = mskQ;
    if (wr && wb_adr_i == `CWG_OFF_CTRL0)
      c0D = wb_dat_i[7:0];
    if (wr && wb_adr_i == `CWG_OFF_CTRL1)
      c1D = wb_dat_i[7:0];
    if (wr && wb_adr_i == `CWG_OFF_SHDN)
      mskD = wb_dat_i[NSRC-1:0];
  end
  // Shadow lags the design by a cycle, so every rule below that reads the shadow allows that slack
  always_ff @(posedge clk_sys)
  begin
    c0Q  <= rst_n ? c0D : 8'h00;
    c1Q  <= rst_n ? c1D : 8'h00;
    mskQ <= rst_n ? mskD : '0;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  bus_answer_a:
    assert property (req |=> wb_ack_o ^ wb_err_o) else $error("bus request not answered");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  err_unmapped_a:
    assert property (req && wb_adr_i > `CWG_OFF_STATUS |=> wb_err_o) else $error("no err");
  err_data_a:
    assert property (wb_err_o |-> wb_dat_o == 32'h0) else $error("err with nonzero data");
  off_low_a:
    assert property (!en [*2] |-> !drive_output_a && !drive_output_b) else $error("drive on");
  enable_override_a:
    assert property ($rose(en) |-> ##[0:2] ovOk) else $error("no override at enable");
  shutdown_override_a:
    assert property ((en && |(shutdown_src & mskQ)) [*4] |-> ovOk) else $error("no override");
  osc_on_a:
    assert property ((en && c0Q[`CWG_C0_CS]) [*2] |-> fast_osc_request)
      else $error("osc request low");
  osc_off_a:
    assert property (!(en && c0Q[`CWG_C0_CS]) [*2] |-> !fast_osc_request)
      else $error("osc request high");
  cover property (en && |(shutdown_src & mskQ));
  cover property (wb_err_o);
  cover property ($rose(fast_osc_request));
endmodule // cwg_top_checker

bind cwg_top cwg_top_checker #(.NSRC(NSRC)) chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .shutdown_src(shutdown_src), .drive_output_a(drive_output_a),
  .drive_output_b(drive_output_b), .fast_osc_request(fast_osc_request));

/* File: bench/cwg_top_tb_top.sv */
// Self-checking bench: registers, source select, polarity, shutdown and restart.
// Assumes the checker is bound and two gate driver models watch the outputs.
`timescale 1ns/1ps
`include "cwg_map.svh"
module cwg_top_tb_top
  import cwg_pkg::*;
;
  logic        clk_sys = 0, rstN = 0, cyc = 0, we = 0, ack, err, outA, outB, oscReq;
  logic        gA, gB, pa = 0, pb = 0, lastErr, countOn = 0;
  logic [7:0]  adr = 0;
  logic [31:0] datW = 0, datR, rdData, v;
  logic [6:0]  srcIn = 0;
  logic [3:0]  sdSrc = 0;
  logic [1:0]  ov;
  int          errorCnt = 0, checksDone = 0, cycles = 0, overlap = 0, k;
  always #4 clk_sys = ~clk_sys;
  cwg_top uut (.clk_sys(clk_sys), .rst_n(rstN), .wb_adr_i(adr), .wb_dat_i(datW),
    .wb_dat_o(datR), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_ack_o(ack), .wb_err_o(err), .external_input_pin(srcIn[0]),
    .comparator_one_synced(srcIn[1]), .comparator_two_synced(srcIn[2]),
    .pulse_channel_one(srcIn[3]), .pulse_channel_two(srcIn[4]),
    .pulse_channel_three(srcIn[5]), .pulse_channel_four(srcIn[6]), .shutdown_src(sdSrc),
    .drive_output_a(outA), .drive_output_b(outB), .fast_osc_request(oscReq));
  cwg_gate_drv drvA (.clk_sys(clk_sys), .rst_n(rstN), .drive(outA), .activeHigh(pa), .gateOn(gA));
  cwg_gate_drv drvB (.clk_sys(clk_sys), .rst_n(rstN), .drive(outB), .activeHigh(pb), .gateOn(gB));
  always @(posedge clk_sys)
  begin
    cycles++;
    if (countOn && gA && gB)
      overlap++;
    if (cycles == 40000)
    begin
      errorCnt++;
      finishTest();
    end
  end
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e)
    begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    adr  <= a;
    we   <= w;
    datW <= d;
    do
      @(posedge clk_sys);
    while (ack !== 1'b1 && err !== 1'b1);
    rdData  = datR;
    lastErr = err;
    cyc <= 1'b0;
  endtask
  // Gives the outputs time to settle, watching the gates only while running
  task automatic waitOut(input string nm, input logic [1:0] e, input logic run);
    int n;
    n = 0;
    repeat (6) @(posedge clk_sys);
    countOn = run;
    while ({outB, outA} !== e && n < 700)
    begin
      @(posedge clk_sys);
      n++;
    end
    countOn = 1'b0;
    chk(nm, {30'h0, e}, {30'h0, outB, outA});
  endtask
  function automatic logic [1:0] expRun(input logic l, input logic a, input logic b);
    return {~l ~^ b, l ~^ a};
  endfunction
  function automatic logic [31:0] c1(input int s);
    return {24'h0, 1'b0, ov[1], 1'b0, ov[0], 1'b0, 3'(s)};
  endfunction
  initial
  begin
    void'($urandom(76));
    repeat (2) @(posedge clk_sys);
    rstN <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      bus(8'(i * 4), 1'b0, 32'h0);
      chk("reset value", 32'h0, rdData);
    end
    bus(8'h40, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, 32'(lastErr));
    for (int i = 0; i < 2; i++)
    begin
      v = $urandom;
      bus(`CWG_OFF_DBR + 8'(i * 4), 1'b1, v);
      bus(`CWG_OFF_DBR + 8'(i * 4), 1'b0, 32'h0);
      chk("dead band", {26'h0, v[5:0]}, rdData);
    end
    $display("test done: registers");
    ov = 2'($urandom);
    bus(`CWG_OFF_CTRL0, 1'b1, 32'h0);
    bus(`CWG_OFF_SHDN, 1'b1, 32'h8f);
    bus(`CWG_OFF_CTRL1, 1'b1, c1(0));
    bus(`CWG_OFF_CTRL0, 1'b1, 32'h80);
    waitOut("override at enable", ov, 1'b0);
    bus(`CWG_OFF_SHDN, 1'b1, 32'h0f);
    waitOut("override until edge", ov, 1'b0);
    bus(`CWG_OFF_STATUS, 1'b0, 32'h0);
    chk("armed status", {29'h0, 1'b1, ov}, rdData);
    for (int s = 0; s < 7; s++)
    begin
      pa <= 1'($urandom);
      pb <= 1'($urandom);
      bus(`CWG_OFF_CTRL1, 1'b1, c1(s));
      bus(`CWG_OFF_CTRL0, 1'b1, {24'h0, 1'b1, 2'b0, pb, pa, 2'b0, 1'($urandom)});
      for (int j = 1; j >= 0; j--)
      begin
        srcIn <= j ? 7'h1 << s : ~(7'h1 << s);
        waitOut("selected source", expRun(1'(j), pa, pb), 1'b1);
      end
    end
    chk("shoot through", 32'h0, 32'(overlap));
    $display("test done: sources");
    k = $urandom_range(3);
    sdSrc <= 4'h1 << k;
    waitOut("forced override", ov, 1'b0);
    bus(`CWG_OFF_STATUS, 1'b0, 32'h0);
    chk("shutdown status", {24'h0, 4'h1 << k, 2'b0, ov}, rdData);
    bus(`CWG_OFF_SHDN, 1'b1, 32'h0f);
    bus(`CWG_OFF_SHDN, 1'b0, 32'h0);
    chk("clear refused", 32'h8f, rdData);
    sdSrc <= 4'h0;
    repeat (4) @(posedge clk_sys);
    bus(`CWG_OFF_SHDN, 1'b1, 32'h0f);
    bus(`CWG_OFF_SHDN, 1'b0, 32'h0);
    chk("software clear", 32'h0f, rdData);
    waitOut("override after clear", ov, 1'b0);
    bus(`CWG_OFF_SHDN, 1'b1, 32'h4f);
    sdSrc <= 4'h1 << k;
    waitOut("forced override", ov, 1'b0);
    sdSrc <= 4'h0;
    repeat (6) @(posedge clk_sys);
    bus(`CWG_OFF_SHDN, 1'b0, 32'h0);
    chk("auto restart", 32'h4f, rdData);
    srcIn <= 7'h7f;
    waitOut("resume on edge", expRun(1'b1, pa, pb), 1'b0);
    $display("test done: shutdown");
    bus(`CWG_OFF_CTRL0, 1'b1, 32'h0);
    waitOut("disabled low", 2'b00, 1'b0);
    bus(`CWG_OFF_CTRL0, 1'b1, 32'h81);
    waitOut("override on enable", ov, 1'b0);
    chk("oscillator request", 32'h1, 32'(oscReq));
    // Reconfiguring with auto-restart still set must not lose the shutdown set
    bus(`CWG_OFF_SHDN, 1'b1, 32'h8f);
    bus(`CWG_OFF_SHDN, 1'b0, 32'h0);
    chk("set beats restart", 32'h8f, rdData);
    $display("test done: enable");
    finishTest();
  end
endmodule // cwg_top_tb_top

/* File: common/cwg_map.svh */
// Register offsets, field positions, reset values and clock rates of the waveform generator.
// Assumes a 32-bit classic Wishbone slave with byte addresses, one register per aligned word.
`ifndef CWG_MAP_SVH
`define CWG_MAP_SVH

`define CWG_ADDR_W           8
`define CWG_OFF_CTRL0        8'h00
`define CWG_OFF_CTRL1        8'h04
`define CWG_OFF_SHDN         8'h08
`define CWG_OFF_DBR          8'h0c
`define CWG_OFF_DBF          8'h10
`define CWG_OFF_STATUS       8'h14

// waveform_control_0
`define CWG_C0_EN            7
`define CWG_C0_POLB          4
`define CWG_C0_POLA          3
`define CWG_C0_CS            0
// waveform_control_1
`define CWG_C1_OVB_HI        7
`define CWG_C1_OVB_LO        6
`define CWG_C1_OVA_HI        5
`define CWG_C1_OVA_LO        4
`define CWG_C1_IS_HI         2
`define CWG_C1_IS_LO         0
// shutdown_control
`define CWG_SD_ASE           7
`define CWG_SD_ARSEN         6
`define CWG_SD_SRC_HI        3
`define CWG_SD_SRC_LO        0
// status
`define CWG_ST_A             0
`define CWG_ST_B             1
`define CWG_ST_ARMED         2
`define CWG_ST_SRC_LO        4

`define CWG_RST_CTRL0        8'h00
`define CWG_RST_CTRL1        8'h00
`define CWG_RST_SHDN         8'h00
`define CWG_RST_DB           6'h00

// Internal fast oscillator 16 MHz against a 125 MHz system clock: enable every 125/16 cycles
`define CWG_SYS_KHZ          125000
`define CWG_FAST_KHZ         16000

`endif

/* File: common/cwg_pkg.sv */
// Types shared by the waveform generator modules.
// Constants live in cwg_map.svh.
package cwg_pkg;
  typedef enum logic [1:0] {
    CWG_OFF    = 2'b00,
    CWG_SHDN   = 2'b01,
    CWG_ARMED  = 2'b10,
    CWG_RUN    = 2'b11
  } cwg_state_t;

  typedef enum logic [2:0] {
    CWG_SRC_PIN  = 3'b000,
    CWG_SRC_CMP1 = 3'b001,
    CWG_SRC_CMP2 = 3'b010,
    CWG_SRC_PWM1 = 3'b011,
    CWG_SRC_PWM2 = 3'b100,
    CWG_SRC_PWM3 = 3'b101,
    CWG_SRC_PWM4 = 3'b110
  } cwg_src_t;
endpackage

/* File: rtl/cwg_deadband.sv */
// One dead-band delay: passes a rise of its input after a programmed count of enable pulses.
// A fall passes at once; count zero passes the rise on the next enabled cycle.
`timescale 1ns/1ps
module cwg_deadband
  import cwg_pkg::*;
#(
  parameter int CW = 6
)(
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          tick,
  input  wire logic          clear,
  input  wire logic          din,
  input  wire logic [CW-1:0] delay,
  output logic               dout
);
  logic [CW-1:0] cntQ;
  logic [CW-1:0] cntD;
  logic          outQ;
  logic          outD;

  always_comb
  begin
    cntD = cntQ;
    outD = outQ;
    if (clear || !din)
    begin
      cntD = '0;
      outD = 1'b0;
    end
    else if (tick && !outQ)
    begin
      if (cntQ >= delay)
        outD = 1'b1;
      else
        cntD = cntQ + CW'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cntQ <= '0;
      outQ <= 1'b0;
    end
    else
    begin
      cntQ <= cntD;
      outQ <= outD;
    end
  end

  assign dout = outQ;
endmodule // cwg_deadband

/* File: rtl/cwg_tick.sv */
// Fractional divider making a one-cycle pulse at the fast oscillator rate.
// Assumes clk_sys runs faster than the oscillator it stands for.
`timescale 1ns/1ps
`include "cwg_map.svh"
module cwg_tick
  import cwg_pkg::*;
#(
  parameter int SYS_KHZ  = `CWG_SYS_KHZ,
  parameter int FAST_KHZ = `CWG_FAST_KHZ
)(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      tick
);
  logic [31:0] accQ;
  logic [31:0] accD;
  logic        tickQ;
  logic        tickD;

  // Phase accumulator keeps the long-run rate exact without a fractional clock
  always_comb
  begin
    if (accQ + 32'(FAST_KHZ) >= 32'(SYS_KHZ))
    begin
      accD  = accQ + 32'(FAST_KHZ) - 32'(SYS_KHZ);
      tickD = 1'b1;
    end
    else
    begin
      accD  = accQ + 32'(FAST_KHZ);
      tickD = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      accQ  <= 32'h0;
      tickQ <= 1'b0;
    end
    else
    begin
      accQ  <= accD;
      tickQ <= tickD;
    end
  end

  assign tick = tickQ;
endmodule // cwg_tick

/* File: rtl/cwg_top.sv */
// Complementary waveform generator with dead band, polarity, shutdown override and restart.
// Assumes comparator and pulse inputs come from logic on clk_sys; the pin input and the
// shutdown sources arrive from outside and are synchronised here.
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cwg_map.svh"
module cwg_top
  import cwg_pkg::*;
#(
  parameter int DBW   = 6,
  parameter int NSRC  = 4
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        external_input_pin,
  input  wire logic        comparator_one_synced,
  input  wire logic        comparator_two_synced,
  input  wire logic        pulse_channel_one,
  input  wire logic        pulse_channel_two,
  input  wire logic        pulse_channel_three,
  input  wire logic        pulse_channel_four,
  input  wire logic [NSRC-1:0] shutdown_src,
  output logic             drive_output_a,
  output logic             drive_output_b,
  output logic             fast_osc_request
);
  // Control registers
  logic [7:0]     ctrl0Q, ctrl0D;
  logic [7:0]     ctrl1Q, ctrl1D;
  logic [7:0]     shdnQ, shdnD;
  logic [DBW-1:0] dbrQ, dbrD;
  logic [DBW-1:0] dbfQ, dbfD;
  logic           aseQ, aseD;
  cwg_state_t     stQ, stD;
  logic           ackQ, ackD;
  logic           errQ, errD;
  logic [31:0]    rdQ, rdD;
  logic           outAQ, outAD;
  logic           outBQ, outBD;
  logic           reqQ, reqD;
  logic           inPrevQ;

  // Synchronisers for off-domain inputs
  logic [1:0]      pinSync;
  logic [NSRC-1:0] sdMeta;
  logic [NSRC-1:0] sdSync;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pinSync <= 2'b00;
      sdMeta  <= '0;
      sdSync  <= '0;
    end
    else
    begin
      pinSync <= {pinSync[0], external_input_pin};
      sdMeta  <= shutdown_src;
      sdSync  <= sdMeta;
    end
  end

  // Field decode used by the datapath; the read path returns the raw registers, with aseQ in place of shutdown_control bit 7
  function automatic logic fieldBit(input logic [7:0] r, input int pos);
    fieldBit = r[pos];
  endfunction

  logic enable, polA, polB, clkSel, arsen;
  logic [2:0] srcSel;
  logic [NSRC-1:0] sdMask;
  assign enable = fieldBit(ctrl0Q, `CWG_C0_EN);
  assign polA   = fieldBit(ctrl0Q, `CWG_C0_POLA);
  assign polB   = fieldBit(ctrl0Q, `CWG_C0_POLB);
  assign clkSel = fieldBit(ctrl0Q, `CWG_C0_CS);
  assign arsen  = fieldBit(shdnQ, `CWG_SD_ARSEN);
  assign srcSel = ctrl1Q[`CWG_C1_IS_HI:`CWG_C1_IS_LO];
  assign sdMask = shdnQ[`CWG_SD_SRC_HI:`CWG_SD_SRC_LO];

  logic sdAny;
  assign sdAny = |(sdSync & sdMask);

  // Input multiplexer
  logic selIn;
  always_comb
  begin
    unique case (srcSel)
      CWG_SRC_PIN:  selIn = pinSync[1];
      CWG_SRC_CMP1: selIn = comparator_one_synced;
      CWG_SRC_CMP2: selIn = comparator_two_synced;
      CWG_SRC_PWM1: selIn = pulse_channel_one;
      CWG_SRC_PWM2: selIn = pulse_channel_two;
      CWG_SRC_PWM3: selIn = pulse_channel_three;
      CWG_SRC_PWM4: selIn = pulse_channel_four;
      default:      selIn = 1'b0;
    endcase
  end

  // Clock choice: every cycle on the system clock, or the oscillator-rate tick
  logic fastTick, dbTick;
  cwg_tick u_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (fastTick)
  );
  assign dbTick = clkSel ? fastTick : 1'b1;

  // Dead band: A rises after the rising delay, B after the falling delay
  logic running, dbA, dbB;
  assign running = (stQ == CWG_RUN);
  cwg_deadband #(.CW(DBW)) u_dbr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (dbTick),
    .clear   (!running),
    .din     (selIn),
    .delay   (dbrQ),
    .dout    (dbA)
  );
  cwg_deadband #(.CW(DBW)) u_dbf (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (dbTick),
    .clear   (!running),
    .din     (!selIn),
    .delay   (dbfQ),
    .dout    (dbB)
  );

  logic risingIn;
  assign risingIn = selIn && !inPrevQ;

  // Wishbone decode
  logic       acc, wr;
  logic [7:0] wbyte;
  assign acc   = wb_cyc_i && wb_stb_i && !ackQ && !errQ;
  assign wr    = acc && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // A software set of the shutdown bit must beat the auto-restart clear of the same cycle
  logic aseSet;
  assign aseSet = wr && (wb_adr_i == `CWG_OFF_SHDN) && wbyte[`CWG_SD_ASE];

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `CWG_OFF_CTRL0) || (a == `CWG_OFF_CTRL1) || (a == `CWG_OFF_SHDN) ||
             (a == `CWG_OFF_DBR) || (a == `CWG_OFF_DBF) || (a == `CWG_OFF_STATUS);
  endfunction

  // Register and shutdown state
  always_comb
  begin
    ctrl0D = ctrl0Q;
    ctrl1D = ctrl1Q;
    shdnD  = shdnQ;
    dbrD   = dbrQ;
    dbfD   = dbfQ;
    aseD   = aseQ;
    ackD   = acc && mapped(wb_adr_i);
    errD   = acc && !mapped(wb_adr_i);
    rdD    = 32'h0;
    if (wr)
    begin
      unique case (wb_adr_i)
        `CWG_OFF_CTRL0: ctrl0D = wbyte;
        `CWG_OFF_CTRL1: ctrl1D = wbyte;
        `CWG_OFF_SHDN:
        begin
          shdnD = wbyte;
          if (wbyte[`CWG_SD_ASE])
            aseD = 1'b1;
          else if (!sdAny)
            aseD = 1'b0;
        end
        `CWG_OFF_DBR:   dbrD = wbyte[DBW-1:0];
        `CWG_OFF_DBF:   dbfD = wbyte[DBW-1:0];
        default:        ;
      endcase
    end
    if (arsen && !sdAny && !aseSet)
      aseD = 1'b0;
    if (sdAny)
      aseD = 1'b1;
    if (acc && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `CWG_OFF_CTRL0:  rdD = {24'h0, ctrl0Q};
        `CWG_OFF_CTRL1:  rdD = {24'h0, ctrl1Q};
        `CWG_OFF_SHDN:   rdD = {24'h0, aseQ, shdnQ[6:0]};
        `CWG_OFF_DBR:    rdD = {26'h0, dbrQ};
        `CWG_OFF_DBF:    rdD = {26'h0, dbfQ};
        `CWG_OFF_STATUS: rdD = {24'h0, sdSync, 1'b0, (stQ == CWG_ARMED), outBQ, outAQ};
        default:         rdD = 32'h0;
      endcase
    end
  end

  // Output state: off, shutdown override, waiting for a rising edge, running
  always_comb
  begin
    stD = stQ;
    if (!enable)
      stD = CWG_OFF;
    else
    begin
      unique case (stQ)
        CWG_OFF:   stD = CWG_SHDN;
        CWG_SHDN:  if (!aseD) stD = CWG_ARMED;
        CWG_ARMED: if (aseD) stD = CWG_SHDN;
                   else if (risingIn) stD = CWG_RUN;
        CWG_RUN:   if (aseD) stD = CWG_SHDN;
      endcase
    end
  end

  always_comb
  begin
    unique case (stD)
      CWG_OFF:
      begin
        outAD = 1'b0;
        outBD = 1'b0;
      end
      CWG_RUN:
      begin
        outAD = running ? (dbA ~^ polA) : !polA;
        outBD = running ? (dbB ~^ polB) : !polB;
      end
      default:
      begin
        outAD = ctrl1Q[`CWG_C1_OVA_LO];
        outBD = ctrl1Q[`CWG_C1_OVB_LO];
      end
    endcase
    reqD = enable && clkSel;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl0Q  <= `CWG_RST_CTRL0;
      ctrl1Q  <= `CWG_RST_CTRL1;
      shdnQ   <= `CWG_RST_SHDN;
      dbrQ    <= `CWG_RST_DB;
      dbfQ    <= `CWG_RST_DB;
      aseQ    <= 1'b0;
      stQ     <= CWG_OFF;
      ackQ    <= 1'b0;
      errQ    <= 1'b0;
      rdQ     <= 32'h0;
      outAQ   <= 1'b0;
      outBQ   <= 1'b0;
      reqQ    <= 1'b0;
      inPrevQ <= 1'b0;
    end
    else
    begin
      ctrl0Q  <= ctrl0D;
      ctrl1Q  <= ctrl1D;
      shdnQ   <= shdnD;
      dbrQ    <= dbrD;
      dbfQ    <= dbfD;
      aseQ    <= aseD;
      stQ     <= stD;
      ackQ    <= ackD;
      errQ    <= errD;
      rdQ     <= rdD;
      outAQ   <= outAD;
      outBQ   <= outBD;
      reqQ    <= reqD;
      inPrevQ <= selIn;
    end
  end

  assign wb_dat_o         = rdQ;
  assign wb_ack_o         = ackQ;
  assign wb_err_o         = errQ;
  assign drive_output_a   = outAQ;
  assign drive_output_b   = outBQ;
  assign fast_osc_request = reqQ;
endmodule // cwg_top
